// [bench/stc_front_model.sv]
`timescale 1ns/10ps
`default_nettype none
module stc_front_model (
    input wire logic i_core_clk,
    input wire logic [stc_pkg::CHAN_W-1:0] i_chan_a,
    input wire logic [stc_pkg::CHAN_W-1:0] i_chan_b,
    input wire logic i_sh_pulse,
    output logic [stc_pkg::RES_W-1:0] o_conv_a_data,
    output logic [stc_pkg::RES_W-1:0] o_conv_b_data,
    output logic [stc_pkg::RES_W-1:0] o_exp_a,
    output logic [stc_pkg::RES_W-1:0] o_exp_b,
    output logic o_evm_a_soc,
    output logic o_evm_b_soc,
    output logic o_ext_soc
);
    logic [7:0] cnt_r = 8'h00;
    initial begin
        {o_conv_a_data, o_conv_b_data, o_exp_a, o_exp_b} = '0;
        {o_evm_a_soc, o_evm_b_soc, o_ext_soc} = 3'h0;
    end
    // Analog values move every cycle, so a sample taken one cycle off gives a wrong result
    always @(posedge i_core_clk) begin
        cnt_r <= cnt_r + 8'h01;
        o_conv_a_data <= {i_chan_a, cnt_r};
        o_conv_b_data <= {i_chan_b, ~cnt_r};
        if (i_sh_pulse) begin
            o_exp_a <= o_conv_a_data;
            o_exp_b <= o_conv_b_data;
        end
    end
    task automatic fire(input int src);
        @(posedge i_core_clk);
        if (src == 1) o_evm_a_soc <= 1'b1;
        else if (src == 2) o_evm_b_soc <= 1'b1;
        else o_ext_soc <= 1'b1;
        @(posedge i_core_clk);
        o_evm_a_soc <= 1'b0;
        o_evm_b_soc <= 1'b0;
        // Pin held a few cycles so the synchroniser cannot miss it
        repeat (3) @(posedge i_core_clk);
        o_ext_soc <= 1'b0;
    endtask
endmodule // stc_front_model
`default_nettype wire

// [bench/stc_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch at %0t: got %h exp %h", $time, (got), (exp)); end end
module stc_tb_top;
    typedef struct packed {
        logic [15:0] ctrl; logic [1:0] src; logic [2:0] mask; logic [7:0] dly;
        logic [7:0] shw; logic [7:0] gap; logic [3:0] ca; logic [3:0] cb; logic [1:0] sts;
    } stc_row_type;
    logic i_core_clk, i_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, o_prdata, rd;
    logic o_pready, o_pslverr, perr, o_sh_pulse, o_capture, o_irq, ev_a, ev_b, ext, sh_q, ext_q;
    logic [11:0] da, db, exp_a, exp_b;
    logic [3:0] o_chan_a, o_chan_b;
    int err_count = 0, checks = 0, cyc = 0, t_start, t_rise, t_fall, t_cap, t_cap_prev, t_irq;
    int ncap = 0, irq_q = 0;
    stc_row_type rows[4];

    stc_top u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_evm_a_soc(ev_a), .i_evm_b_soc(ev_b),
        .i_ext_soc(ext), .i_conv_a_data(da), .i_conv_b_data(db), .o_sh_pulse(o_sh_pulse),
        .o_capture(o_capture), .o_chan_a(o_chan_a), .o_chan_b(o_chan_b), .o_irq(o_irq));
    stc_front_model u_fe (.i_core_clk(i_core_clk), .i_chan_a(o_chan_a), .i_chan_b(o_chan_b),
        .i_sh_pulse(o_sh_pulse), .o_conv_a_data(da), .o_conv_b_data(db), .o_exp_a(exp_a),
        .o_exp_b(exp_b), .o_evm_a_soc(ev_a), .o_evm_b_soc(ev_b), .o_ext_soc(ext));

    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    // Edge stamps, each taken at the edge that ends the cycle in which the event shows
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        sh_q <= o_sh_pulse;
        ext_q <= ext;
        irq_q <= o_irq;
        if (psel && penable && o_pready && pwrite && paddr == stc_pkg::TRIG_OFF && pwdata[0])
            t_start <= cyc;
        if (ev_a || ev_b || (ext && !ext_q)) t_start <= cyc;
        if (o_sh_pulse && !sh_q) t_rise <= cyc;
        if (!o_sh_pulse && sh_q) t_fall <= cyc;
        if (o_irq && irq_q == 0) t_irq <= cyc;
        if (o_capture) begin
            t_cap <= cyc;
            t_cap_prev <= t_cap;
            ncap <= ncap + 1;
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_core_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge i_core_clk);
        while (o_pready !== 1'b1 && n < 20) begin
            @(posedge i_core_clk);
            n++;
        end
        if (o_pready !== 1'b1) begin
            err_count++;
            print_verdict();
        end
        rd = o_prdata;
        perr = o_pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 300 && o_irq !== 1'b1; n++) @(posedge i_core_clk) #1;
        if (o_irq !== 1'b1) begin
            err_count++;
            print_verdict();
        end
        @(posedge i_core_clk) #1;
    endtask
    task automatic wait_caps(input int k);
        for (int n = 0; n < 300 && ncap < k; n++) @(posedge i_core_clk) #1;
        if (ncap < k) begin
            err_count++;
            print_verdict();
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #(50 * 6000);
        err_count++;
        print_verdict();
    end

    initial begin
        // Irq rises with the status bit: 8 cycles A result lag (10 for B in row 2) plus 2 cycles flag lag
        rows[0] = '{16'h5070, 2'd0, 3'h3, 8'd6, 8'd2, 8'd10, 4'h5, 4'h5, 2'h1};
        rows[1] = '{16'haf70, 2'd1, 3'h3, 8'd6, 8'd32, 8'd10, 4'ha, 4'ha, 2'h1};
        // matched pair 3, top select bit set
        rows[2] = '{16'hb371, 2'd2, 3'h2, 8'd6, 8'd8, 8'd12, 4'h3, 4'hb, 2'h3};
        rows[3] = '{16'hf170, 2'd3, 3'h3, 8'd9, 8'd4, 8'd10, 4'hf, 4'hf, 2'h1};
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        apb(1'b0, stc_pkg::CTRL_OFF, 32'h0);
        `CHK({rd, o_irq, o_sh_pulse}, 34'h0)
        apb(1'b0, stc_pkg::STATUS_OFF, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, stc_pkg::MASK_OFF, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h20, 32'h0);
        `CHK({perr, rd}, 33'h100000000)
        apb(1'b1, stc_pkg::CTRL_OFF, 32'hffff);
        apb(1'b0, stc_pkg::CTRL_OFF, 32'h0);
        `CHK(rd, 32'hff73)
        $display("test registers done");
        foreach (rows[i]) begin
            apb(1'b1, stc_pkg::MASK_OFF, 32'(rows[i].mask));
            apb(1'b1, stc_pkg::CTRL_OFF, 32'(rows[i].ctrl));
            if (rows[i].src == 2'd0) apb(1'b1, stc_pkg::TRIG_OFF, 32'h1);
            else u_fe.fire(int'(rows[i].src));
            wait_irq();
            `CHK(t_rise - t_start, int'(rows[i].dly))
            `CHK(t_fall - t_rise, int'(rows[i].shw))
            `CHK(t_cap, t_fall)
            `CHK(t_irq - t_cap, int'(rows[i].gap))
            `CHK({o_chan_a, o_chan_b}, {rows[i].ca, rows[i].cb})
            repeat (4) @(posedge i_core_clk);
            apb(1'b0, stc_pkg::RES_A_OFF, 32'h0);
            `CHK(rd, 32'(exp_a))
            apb(1'b0, stc_pkg::RES_B_OFF, 32'h0);
            if (rows[i].ctrl[0]) `CHK(rd, 32'(exp_b))
            apb(1'b0, stc_pkg::STATUS_OFF, 32'h0);
            `CHK(rd, 32'(rows[i].sts))
            apb(1'b1, stc_pkg::STATUS_OFF, 32'h7);
            apb(1'b0, stc_pkg::STATUS_OFF, 32'h0);
            `CHK({rd, o_irq}, 33'h0)
            $display("test row %0d done", i);
        end
        // Continuous sequential run, prescale 1, channel 2, interrupts masked
        apb(1'b1, stc_pkg::MASK_OFF, 32'h0);
        apb(1'b1, stc_pkg::CTRL_OFF, 32'h2102);
        apb(1'b1, stc_pkg::TRIG_OFF, 32'h1);
        wait_caps(ncap + 3);
        `CHK(t_cap - t_cap_prev, (2 + 1) * stc_pkg::CONV_CYC)
        apb(1'b1, stc_pkg::TRIG_OFF, 32'h1);
        apb(1'b0, stc_pkg::STATUS_OFF, 32'h0);
        `CHK({rd[8], rd[2], o_irq}, 3'b110)
        apb(1'b1, stc_pkg::CTRL_OFF, 32'h2100);
        repeat (30) @(posedge i_core_clk);
        // Continuous simultaneous run on pair 3
        apb(1'b1, stc_pkg::CTRL_OFF, 32'h3103);
        apb(1'b1, stc_pkg::TRIG_OFF, 32'h1);
        wait_caps(ncap + 3);
        `CHK(t_cap - t_cap_prev, (3 + 1) * stc_pkg::CONV_CYC)
        apb(1'b1, stc_pkg::CTRL_OFF, 32'h3101);
        repeat (30) @(posedge i_core_clk);
        $display("test continuous done");
        // Reset in the middle of a long pulse
        apb(1'b1, stc_pkg::CTRL_OFF, 32'h5f00);
        apb(1'b1, stc_pkg::TRIG_OFF, 32'h1);
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        `CHK({o_sh_pulse, o_capture, o_irq, o_chan_a, o_chan_b}, 11'h0)
        i_rst <= 1'b0;
        apb(1'b0, stc_pkg::STATUS_OFF, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, stc_pkg::CTRL_OFF, 32'h0);
        `CHK(rd, 32'h0)
        $display("test reset done");
        print_verdict();
    end
endmodule // stc_tb_top
`default_nettype wire

// [hw/stc_delay_line.sv]
`timescale 1ns/10ps
`default_nettype none
module stc_delay_line #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_data,
    output logic [WIDTH-1:0] o_data
);
    logic [WIDTH-1:0] pipe_r [DEPTH];

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                pipe_r[i] <= '0;
            end
        end else begin
            pipe_r[0] <= i_data;
            for (int i = 1; i < DEPTH; i++) begin
                pipe_r[i] <= pipe_r[i-1];
            end
        end
    end

    assign o_data = pipe_r[DEPTH-1];
endmodule // stc_delay_line
`default_nettype wire

// [hw/stc_pkg.sv]
package stc_pkg;
    // Converter clock runs at half the 20 MHz core clock, so half periods are whole cycles
    localparam int CORE_PERIOD_NS = 50;
    localparam int CONV_CYC = 2;
    localparam int CONV_PERIOD_NS = CONV_CYC * CORE_PERIOD_NS;
    localparam int TRIG_DLY_HALF_PER = 5;
    localparam int RES_A_DLY_PER = 4;
    localparam int RES_B_DLY_PER = 5;
    localparam int SEQ_GAP_PER = 1;
    localparam int SIM_GAP_PER = 2;
    localparam int IRQ_DLY_CYC = 2;
    localparam int RES_W = 12;
    localparam int CHAN_W = 4;
    localparam int ACQ_W = 4;
    localparam int CNT_W = 6;
    localparam int TRIG_DLY_CYC = (TRIG_DLY_HALF_PER * CONV_CYC + 1) / 2;
    localparam int RES_A_DLY_CYC = RES_A_DLY_PER * CONV_CYC;
    localparam int RES_B_DLY_CYC = RES_B_DLY_PER * CONV_CYC;
    localparam logic [CNT_W-1:0] TRIG_DLY_LD = CNT_W'(TRIG_DLY_CYC - 1);
    localparam logic [CNT_W-1:0] SEQ_GAP_LD = CNT_W'(SEQ_GAP_PER * CONV_CYC - 1);
    localparam logic [CNT_W-1:0] SIM_GAP_LD = CNT_W'(SIM_GAP_PER * CONV_CYC - 1);

    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] TRIG_OFF = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;
    localparam logic [7:0] MASK_OFF = 8'h0c;
    localparam logic [7:0] RES_A_OFF = 8'h10;
    localparam logic [7:0] RES_B_OFF = 8'h14;

    localparam int CTRL_SAMPLING_MODE_SELECT_BIT = 0;
    localparam int CTRL_CONT_BIT = 1;
    localparam int CTRL_EVM_A_EN_BIT = 4;
    localparam int CTRL_EVM_B_EN_BIT = 5;
    localparam int CTRL_EXT_EN_BIT = 6;
    localparam int CTRL_ACQ_LSB = 8;
    localparam int CTRL_CHAN_LSB = 12;
    localparam int CTRL_W = 16;
    localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [CTRL_W-1:0] CTRL_MASK = 16'hff73;
    localparam int TRIG_SW_BIT = 0;
    localparam int STS_RES_A_BIT = 0;
    localparam int STS_RES_B_BIT = 1;
    localparam int STS_OVR_BIT = 2;
    localparam int STS_BUSY_BIT = 8;
    localparam int STS_W = 3;
    localparam logic [STS_W-1:0] STS_RST = 3'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DLY = 4'b0010,
        ST_SH = 4'b0100,
        ST_GAP = 4'b1000
    } stc_state_type;

    // Sample/hold pulse length in core cycles, loaded as count minus one
    function automatic logic [CNT_W-1:0] sh_load(input logic [ACQ_W-1:0] acq);
        sh_load = CNT_W'((32'(acq) + 32'd1) * CONV_CYC - 1);
    endfunction
endpackage

// [hw/stc_sync3.sv]
`timescale 1ns/10ps
`default_nettype none
module stc_sync3 (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_s2,
    output logic o_s3
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign o_s2 = s2_r;
    assign o_s3 = s3_r;
endmodule // stc_sync3
`default_nettype wire

// [hw/stc_top.sv]
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module stc_top #(
    parameter int RES_A_DLY = stc_pkg::RES_A_DLY_CYC,
    parameter int RES_B_DLY = stc_pkg::RES_B_DLY_CYC,
    parameter int IRQ_DLY = stc_pkg::IRQ_DLY_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_evm_a_soc,
    input wire logic i_evm_b_soc,
    input wire logic i_ext_soc,
    input wire logic [stc_pkg::RES_W-1:0] i_conv_a_data,
    input wire logic [stc_pkg::RES_W-1:0] i_conv_b_data,
    output logic o_sh_pulse,
    output logic o_capture,
    output logic [stc_pkg::CHAN_W-1:0] o_chan_a,
    output logic [stc_pkg::CHAN_W-1:0] o_chan_b,
    output logic o_irq
);
    localparam int LW = stc_pkg::RES_W + 1;

    stc_pkg::stc_state_type state_r;
    stc_pkg::stc_state_type state_nxt;
    logic [stc_pkg::CNT_W-1:0] cnt_r;
    logic [stc_pkg::CNT_W-1:0] cnt_nxt;
    logic [stc_pkg::CTRL_W-1:0] ctrl_r;
    logic [stc_pkg::STS_W-1:0] sts_r;
    logic [stc_pkg::STS_W-1:0] sts_nxt;
    logic [stc_pkg::STS_W-1:0] mask_r;
    logic [stc_pkg::RES_W-1:0] res_a_r;
    logic [stc_pkg::RES_W-1:0] res_b_r;
    logic run_sampling_mode_select_r;
    logic [stc_pkg::ACQ_W-1:0] run_acq_r;
    logic sh_r;
    logic capt_r;
    logic [stc_pkg::CHAN_W-1:0] chan_a_r;
    logic [stc_pkg::CHAN_W-1:0] chan_b_r;
    logic irq_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic ext_level_r;
    logic ext_s2;
    logic ext_s3;
    logic [LW-1:0] line_a_out;
    logic [LW-1:0] line_b_out;
    logic [1:0] flag_dly_out;

    // Bus decode
    wire apb_setup = i_psel & ~i_penable;
    wire apb_done = i_psel & i_penable & pready_r;
    wire hit_ctrl = (i_paddr == stc_pkg::CTRL_OFF);
    wire hit_trig = (i_paddr == stc_pkg::TRIG_OFF);
    wire hit_sts = (i_paddr == stc_pkg::STATUS_OFF);
    wire hit_mask = (i_paddr == stc_pkg::MASK_OFF);
    wire hit_res_a = (i_paddr == stc_pkg::RES_A_OFF);
    wire hit_res_b = (i_paddr == stc_pkg::RES_B_OFF);
    wire addr_ok = hit_ctrl | hit_trig | hit_sts | hit_mask | hit_res_a | hit_res_b;
    wire wr_fire = apb_done & i_pwrite & addr_ok;
    wire busy = (state_r != stc_pkg::ST_IDLE);
    wire [31:0] sts_word = 32'({busy, 5'h00, sts_r});
    wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl_r) :
                         hit_sts ? sts_word :
                         hit_mask ? 32'(mask_r) :
                         hit_res_a ? 32'(res_a_r) :
                         hit_res_b ? 32'(res_b_r) : 32'h0000_0000;

    // Control fields
    wire sampling_mode_select = ctrl_r[stc_pkg::CTRL_SAMPLING_MODE_SELECT_BIT];
    wire cont_en = ctrl_r[stc_pkg::CTRL_CONT_BIT];
    wire [stc_pkg::ACQ_W-1:0] acq_fld = ctrl_r[stc_pkg::CTRL_ACQ_LSB +: stc_pkg::ACQ_W];
    wire [stc_pkg::CHAN_W-1:0] chan_fld = ctrl_r[stc_pkg::CTRL_CHAN_LSB +: stc_pkg::CHAN_W];
    // Only the pair index is used; the side bit of the field is ignored here
    wire [stc_pkg::CHAN_W-1:0] pair_a = {1'b0, chan_fld[stc_pkg::CHAN_W-2:0]};
    wire [stc_pkg::CHAN_W-1:0] pair_b = {1'b1, chan_fld[stc_pkg::CHAN_W-2:0]};

    stc_sync3 u_ext_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_ext_soc),
        .o_s2(ext_s2),
        .o_s3(ext_s3)
    );

    // A pin edge counts only once two sync stages agree
    wire ext_stable = (ext_s2 == ext_s3);
    wire ext_rise = ext_stable & ext_s3 & ~ext_level_r;

    wire sw_trig = wr_fire & hit_trig & i_pwdata[stc_pkg::TRIG_SW_BIT];
    wire trig_any = sw_trig
        | (i_evm_a_soc & ctrl_r[stc_pkg::CTRL_EVM_A_EN_BIT])
        | (i_evm_b_soc & ctrl_r[stc_pkg::CTRL_EVM_B_EN_BIT])
        | (ext_rise & ctrl_r[stc_pkg::CTRL_EXT_EN_BIT]);
    wire trig_take = trig_any & ~busy;
    // A start during a run is not queued; software sees it in the status word
    wire trig_lost = trig_any & busy;

    wire cnt_zero = (cnt_r == '0);
    wire sh_end = (state_r == stc_pkg::ST_SH) & cnt_zero;
    wire gap_end = (state_r == stc_pkg::ST_GAP) & cnt_zero;
    wire capt_b = sh_end & run_sampling_mode_select_r;

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_zero ? cnt_r : cnt_r - 1'b1;
        case (state_r)
            stc_pkg::ST_IDLE: begin
                if (trig_take) begin
                    state_nxt = stc_pkg::ST_DLY;
                    cnt_nxt = stc_pkg::TRIG_DLY_LD;
                end
            end
            stc_pkg::ST_DLY: begin
                if (cnt_zero) begin
                    state_nxt = stc_pkg::ST_SH;
                    cnt_nxt = stc_pkg::sh_load(run_acq_r);
                end
            end
            stc_pkg::ST_SH: begin
                if (cnt_zero) begin
                    state_nxt = stc_pkg::ST_GAP;
                    cnt_nxt = run_sampling_mode_select_r ? stc_pkg::SIM_GAP_LD : stc_pkg::SEQ_GAP_LD;
                end
            end
            stc_pkg::ST_GAP: begin
                if (cnt_zero) begin
                    if (cont_en) begin
                        state_nxt = stc_pkg::ST_SH;
                        cnt_nxt = stc_pkg::sh_load(run_acq_r);
                    end else begin
                        state_nxt = stc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = stc_pkg::ST_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= stc_pkg::ST_IDLE;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Mode, prescale and channels are frozen for a run; the next run picks up new values
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            run_sampling_mode_select_r <= 1'b0;
            run_acq_r <= '0;
            chan_a_r <= '0;
            chan_b_r <= '0;
        end else if (trig_take) begin
            run_sampling_mode_select_r <= sampling_mode_select;
            run_acq_r <= acq_fld;
            chan_a_r <= sampling_mode_select ? pair_a : chan_fld;
            chan_b_r <= sampling_mode_select ? pair_b : chan_fld;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_r <= 1'b0;
            capt_r <= 1'b0;
        end else begin
            sh_r <= (state_nxt == stc_pkg::ST_SH);
            capt_r <= sh_end;
        end
    end

    // capture on the pulse fall; eight-stage pipeline latency (four converter periods)
    stc_delay_line #(.WIDTH(LW), .DEPTH(RES_A_DLY)) u_line_a (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_data({sh_end, i_conv_a_data}),
        .o_data(line_a_out)
    );

    // B result one period after A
    stc_delay_line #(.WIDTH(LW), .DEPTH(RES_B_DLY)) u_line_b (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_data({capt_b, i_conv_b_data}),
        .o_data(line_b_out)
    );

    wire res_a_we = line_a_out[LW-1];
    wire res_b_we = line_b_out[LW-1];

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            res_a_r <= '0;
            res_b_r <= '0;
        end else begin
            if (res_a_we) begin
                res_a_r <= line_a_out[stc_pkg::RES_W-1:0];
            end
            if (res_b_we) begin
                res_b_r <= line_b_out[stc_pkg::RES_W-1:0];
            end
        end
    end

    // flags trail the update by a fixed count
    stc_delay_line #(.WIDTH(2), .DEPTH(IRQ_DLY)) u_flag_dly (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_data({res_b_we, res_a_we}),
        .o_data(flag_dly_out)
    );

    // Set wins over a write-one clear in the same cycle
    wire [stc_pkg::STS_W-1:0] sts_set = {trig_lost, flag_dly_out};
    wire [stc_pkg::STS_W-1:0] sts_clr = (wr_fire & hit_sts) ? i_pwdata[stc_pkg::STS_W-1:0] : '0;
    assign sts_nxt = (sts_r & ~sts_clr) | sts_set;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r <= stc_pkg::CTRL_RST;
            mask_r <= stc_pkg::STS_RST;
            sts_r <= stc_pkg::STS_RST;
            irq_r <= 1'b0;
            ext_level_r <= 1'b0;
        end else begin
            if (wr_fire & hit_ctrl) begin
                ctrl_r <= i_pwdata[stc_pkg::CTRL_W-1:0] & stc_pkg::CTRL_MASK;
            end
            if (wr_fire & hit_mask) begin
                mask_r <= i_pwdata[stc_pkg::STS_W-1:0];
            end
            sts_r <= sts_nxt;
            irq_r <= |(sts_nxt & mask_r);
            if (ext_stable) begin
                ext_level_r <= ext_s3;
            end
        end
    end

    // Zero wait states: ready in every access phase, read data fetched in setup
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup & ~addr_ok;
            if (apb_setup) begin
                prdata_r <= i_pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_sh_pulse = sh_r;
    assign o_capture = capt_r;
    assign o_chan_a = chan_a_r;
    assign o_chan_b = chan_b_r;
    assign o_irq = irq_r;

    // Helper logic for checks
    logic [stc_pkg::CNT_W-1:0] sh_len_r;
    logic [7:0] since_a_r;
    logic seen_a_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_len_r <= '0;
            since_a_r <= '0;
            seen_a_r <= 1'b0;
        end else begin
            sh_len_r <= sh_r ? sh_len_r + 1'b1 : '0;
            since_a_r <= res_a_we ? 8'h01 : since_a_r + 8'h01;
            seen_a_r <= res_a_we | (seen_a_r & busy);
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    a_trig_to_sample: assert property (trig_take |-> ##6 $rose(o_sh_pulse))
        else $error("sample did not start 2.5 periods after trigger");
    a_sh_width: assert property ($fell(o_sh_pulse) |->
        32'(sh_len_r) == (32'(run_acq_r) + 1) * stc_pkg::CONV_CYC)
        else $error("sample/hold width wrong");
    a_first_res_a: assert property ($rose(o_capture) |-> ##7 res_a_we)
        else $error("A result not written four periods after sampling");
    a_seq_spacing: assert property (res_a_we && seen_a_r && $past(busy) && !run_sampling_mode_select_r |->
        32'(since_a_r) == (32'(run_acq_r) + 2) * stc_pkg::CONV_CYC)
        else $error("sequential result spacing wrong");
    a_b_after_a: assert property (o_capture && run_sampling_mode_select_r |->
        ##7 res_a_we ##1 !res_b_we ##1 res_b_we)
        else $error("B result not one period after A");
    a_sim_spacing: assert property (res_a_we && seen_a_r && $past(busy) && run_sampling_mode_select_r |->
        32'(since_a_r) == (32'(run_acq_r) + 3) * stc_pkg::CONV_CYC)
        else $error("simultaneous result spacing wrong");
    a_pair_matched: assert property (run_sampling_mode_select_r && busy |->
        o_chan_a[2:0] == o_chan_b[2:0] && !o_chan_a[3] && o_chan_b[3])
        else $error("channel pair not matched");
    a_capture_both: assert property (capt_b |-> sh_end && o_sh_pulse)
        else $error("B captured apart from A");
    a_flag_after_res: assert property ($rose(sts_r[stc_pkg::STS_RES_A_BIT]) |->
        $past(res_a_we, 3))
        else $error("flag set without earlier result update");
    a_flag_delay: assert property (res_a_we |-> ##3 sts_r[stc_pkg::STS_RES_A_BIT])
        else $error("flag not set at fixed delay");
    a_ext_start: assert property (ext_rise && ctrl_r[stc_pkg::CTRL_EXT_EN_BIT] && !busy
        |=> state_r == stc_pkg::ST_DLY)
        else $error("external start ignored");
    a_lost_flag: assert property (trig_lost |=> sts_r[stc_pkg::STS_OVR_BIT])
        else $error("start while busy not flagged");

    c_seq_run: cover property (res_a_we && !run_sampling_mode_select_r);
    c_sim_run: cover property (res_b_we && run_sampling_mode_select_r);
    c_cont_run: cover property (res_a_we && seen_a_r && cont_en);
    c_irq_out: cover property ($rose(o_irq));
    c_lost_start: cover property (trig_lost);
endmodule // stc_top
`default_nettype wire
